// ---- hdl/mmrb_bank.sv ----
// misc board register bank: ident, heartbeat, control, cache straps, reset cause
`timescale 1ns/1ps
`include "mmrb_defs.svh"

//Contract
//- memory ident register reads back the installed memory module strap bits
//- odd ident bits report refresh mode: 0 normal, 1 self refresh
//- each rising heartbeat clock edge sets a sticky heartbeat status bit
//- any write to the heartbeat register clears status and its request, unless a new heartbeat edge lands in the same cycle
//- control register is read/write and every system reset clears it
//- control bits 1:0 pick one of four 1 MB flash windows
//- control bit 2 drives flash write enable to all four flash parts
//- bit 3 mirrors flash switch; switch off blocks flash write enable
//- bit 5 lets watchdog expiry reset the board unless diagnostics run
//- control bit 7 inverts the counter zero gate polarity
//- cache config register reports the 3-bit size and speed straps
//- reset cause bits: watchdog, front panel, vme, power-up
//- one cause register is seen at a primary and two alias offsets
//- primary offset clears cause bits on write; first alias is read-only
//- any write to the second alias sets bits 4:0, test only
//- watchdog cause bit sets at timeout, on the same clock as the reset request it causes
//- diagnostics bit set blocks every board reset, watchdog included
//- system reset clears all logic except the reset cause register and its power-on synchroniser
//- system reset drops watchdog enable, making watchdog reset one-shot
module mmrb_bank #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic pwr_on_n,
  input wire mmrb_pkg::mmrb_nb_req_t nb_req,
  output logic [7:0] nb_rdata,
  output logic nb_rvalid,
  input wire logic [7:0] mem_id_pins,
  input wire logic [2:0] bcache_pins,
  input wire logic flash_sw_pin,
  input wire logic hb_clk_pin,
  input wire logic wdt_expire_pin,
  input wire logic panel_reset_pin,
  input wire logic vme_reset_pin,
  input wire logic counter_zero_gate_pin,
  output logic [1:0] flash_win,
  output logic flash_we,
  output logic counter_zero_gate,
  output logic hb_irq,
  output logic board_reset_req
);

  // ****************************************
  // address decode
  // ****************************************
  // full 12-bit compare, so no partial-decode aliases
  function automatic logic hit(input mmrb_pkg::mmrb_nb_req_t req, input logic [11:0] off);
    hit = (req.addr == off);
  endfunction : hit

  logic wr_hb_clear;
  logic wr_board_ctl;
  logic wr_cause_clr;
  logic wr_cause_set;
  logic rd_cause;
  logic rd_mem_ident;
  logic rd_board_ctl;
  logic rd_bcache;

  assign wr_hb_clear = nb_req.wr && hit(nb_req, `MMRB_OFF_HB_CLEAR);
  assign wr_board_ctl = nb_req.wr && hit(nb_req, `MMRB_OFF_BOARD_CTL);
  assign wr_cause_clr = nb_req.wr && hit(nb_req, `MMRB_OFF_CAUSE_CLR);
  assign wr_cause_set = nb_req.wr && hit(nb_req, `MMRB_OFF_CAUSE_SET);

  // the three cause offsets all read one record
  assign rd_cause = hit(nb_req, `MMRB_OFF_CAUSE_CLR) || hit(nb_req, `MMRB_OFF_CAUSE_RD)
      || hit(nb_req, `MMRB_OFF_CAUSE_SET);
  assign rd_mem_ident = hit(nb_req, `MMRB_OFF_MEM_IDENT);
  assign rd_board_ctl = hit(nb_req, `MMRB_OFF_BOARD_CTL);
  assign rd_bcache = hit(nb_req, `MMRB_OFF_BCACHE);

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int PIN_W = $bits(mmrb_pkg::mmrb_pins_t);

  mmrb_pkg::mmrb_pins_t pins_raw;
  mmrb_pkg::mmrb_pins_t pins_s;
  logic [PIN_W-1:0] sync_ff [SYNC_STAGES];

  assign pins_raw.mem_id = mem_id_pins;
  assign pins_raw.bcache = bcache_pins;
  assign pins_raw.flash_sw = flash_sw_pin;
  assign pins_raw.hb_clk = hb_clk_pin;
  assign pins_raw.wdt_expire = wdt_expire_pin;
  assign pins_raw.panel_reset = panel_reset_pin;
  assign pins_raw.vme_reset = vme_reset_pin;
  assign pins_raw.tmr0_gate = counter_zero_gate_pin;

  // each stage of the chain reads only the stage before it
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_STAGES; gi++) begin : g_sync
      if (gi == 0) begin : g_first
        always_ff @(posedge mclk) begin
          if (!resetn) begin
            sync_ff[gi] <= '0;
          end else begin
            sync_ff[gi] <= pins_raw;
          end
        end
      end else begin : g_next
        always_ff @(posedge mclk) begin
          if (!resetn) begin
            sync_ff[gi] <= '0;
          end else begin
            sync_ff[gi] <= sync_ff[gi-1];
          end
        end
      end
    end
  endgenerate

  // pins read zero during reset and arrive two clocks after release
  assign pins_s = sync_ff[SYNC_STAGES-1];

  // power-on level kept apart: it must not be masked by the system reset
  logic pwr_on_meta_ff;
  logic pwr_on_n_ff;

  always_ff @(posedge mclk) begin
    pwr_on_meta_ff <= pwr_on_n;
    pwr_on_n_ff <= pwr_on_meta_ff;
  end

  // ****************************************
  // edge detection on synchronised pins
  // ****************************************
  logic hb_clk_d_ff;
  logic wdt_d_ff;
  logic panel_d_ff;
  logic vme_d_ff;
  logic hb_rise;
  logic wdt_rise;
  logic panel_rise;
  logic vme_rise;

  // reset values match the idle-low pins, so no false edge after reset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hb_clk_d_ff <= 1'b0;
      wdt_d_ff <= 1'b0;
      panel_d_ff <= 1'b0;
      vme_d_ff <= 1'b0;
    end else begin
      hb_clk_d_ff <= pins_s.hb_clk;
      wdt_d_ff <= pins_s.wdt_expire;
      panel_d_ff <= pins_s.panel_reset;
      vme_d_ff <= pins_s.vme_reset;
    end
  end

  assign hb_rise = pins_s.hb_clk && !hb_clk_d_ff;
  assign wdt_rise = pins_s.wdt_expire && !wdt_d_ff;
  assign panel_rise = pins_s.panel_reset && !panel_d_ff;
  assign vme_rise = pins_s.vme_reset && !vme_d_ff;

  // ****************************************
  // heartbeat status
  // ****************************************
  logic hb_ff;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hb_ff <= 1'b0;
    end else if (hb_rise) begin
      // a new edge wins over a clearing write in the same cycle
      hb_ff <= 1'b1;
    end else if (wr_hb_clear) begin
      hb_ff <= 1'b0;
    end
  end

  // request stays up until software writes the clear offset
  assign hb_irq = hb_ff;

  // ****************************************
  // board control register
  // ****************************************
  mmrb_pkg::mmrb_ctl_t ctl_ff;
  mmrb_pkg::mmrb_ctl_t wr_ctl;

  assign wr_ctl = mmrb_pkg::mmrb_ctl_t'(nb_req.wdata);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      // dropping wdt_en here makes a watchdog reset one-shot
      ctl_ff <= mmrb_pkg::mmrb_ctl_t'(`MMRB_CTL_RESET);
    end else if (wr_board_ctl) begin
      // switch and undefined bits are not stored
      ctl_ff.flash_win <= wr_ctl.flash_win;
      ctl_ff.flash_we <= wr_ctl.flash_we;
      ctl_ff.wdt_en <= wr_ctl.wdt_en;
      ctl_ff.tmr0_inv <= wr_ctl.tmr0_inv;
    end
  end

  // read view: switch mirrored live, undefined bits forced low
  mmrb_pkg::mmrb_ctl_t ctl_view;

  always_comb begin
    ctl_view = ctl_ff;
    ctl_view.flash_sw = pins_s.flash_sw;
    ctl_view.rsv4 = 1'b0;
    ctl_view.rsv6 = 1'b0;
  end

  // ****************************************
  // flash and timer gate outputs
  // ****************************************
  logic [1:0] flash_win_ff;
  logic flash_we_ff;
  logic gate_ff;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flash_win_ff <= 2'h0;
      flash_we_ff <= 1'b0;
    end else begin
      flash_win_ff <= ctl_ff.flash_win;
      // gated after the register: a set enable bit cannot outlast the switch
      flash_we_ff <= ctl_ff.flash_we && pins_s.flash_sw;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      gate_ff <= 1'b0;
    end else begin
      gate_ff <= pins_s.tmr0_gate ^ ctl_ff.tmr0_inv;
    end
  end

  assign flash_win = flash_win_ff;
  assign flash_we = flash_we_ff;
  assign counter_zero_gate = gate_ff;

  // ****************************************
  // reset cause record
  // ****************************************
  logic [4:0] cause_ff;
  logic [4:0] nxt_cause;
  logic diag;
  logic wdt_fire;

  // unknown until the first power-on pulse: hold pwr_on_n low three clocks
  assign diag = cause_ff[`MMRB_CAUSE_DIAG];
  // the watchdog cause is recorded even while diagnostics block the reset
  assign wdt_fire = wdt_rise && ctl_ff.wdt_en;

  always_comb begin
    nxt_cause = cause_ff;
    if (wr_cause_clr) begin
      nxt_cause = cause_ff & ~(nb_req.wdata[4:0] & `MMRB_CAUSE_CLR_MASK);
    end
    if (wr_cause_set) begin
      nxt_cause = `MMRB_CAUSE_SET_ALL;
    end
    // hardware events win over a clearing write
    if (wdt_fire) begin
      nxt_cause[`MMRB_CAUSE_WDT] = 1'b1;
    end
    if (panel_rise) begin
      nxt_cause[`MMRB_CAUSE_PANEL] = 1'b1;
    end
    if (vme_rise) begin
      nxt_cause[`MMRB_CAUSE_VME] = 1'b1;
    end
    if (!pwr_on_n_ff) begin
      nxt_cause = `MMRB_CAUSE_PWRUP_VAL;
    end
  end

  // no system reset here: the record outlives it
  always_ff @(posedge mclk) begin
    cause_ff <= nxt_cause;
  end

  // ****************************************
  // board reset request
  // ****************************************
  logic reset_src;
  logic board_rst_ff;

  // level sources hold the request while high; the watchdog gives one pulse
  assign reset_src = wdt_fire || pins_s.panel_reset || pins_s.vme_reset;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      board_rst_ff <= 1'b0;
    end else begin
      board_rst_ff <= !diag && reset_src;
    end
  end

  assign board_reset_req = board_rst_ff;

  // ****************************************
  // read path
  // ****************************************
  logic [7:0] nxt_rdata;
  logic [7:0] rdata_ff;
  logic rvalid_ff;

  always_comb begin
    nxt_rdata = `MMRB_RDATA_UNMAPPED;
    if (rd_cause) begin
      nxt_rdata = {3'h0, cause_ff};
    end else if (rd_mem_ident) begin
      nxt_rdata = pins_s.mem_id;
    end else if (rd_board_ctl) begin
      nxt_rdata = ctl_view;
    end else if (rd_bcache) begin
      nxt_rdata = {5'h00, pins_s.bcache};
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= nb_req.rd;
      if (nb_req.rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // read data holds until the next read
  assign nb_rdata = rdata_ff;
  assign nb_rvalid = rvalid_ff;

endmodule : mmrb_bank

// ---- hdl/mmrb_defs.svh ----
// offsets, field positions and reset values of the misc register bank
`ifndef MMRB_DEFS_SVH
`define MMRB_DEFS_SVH

// ****************************************
// local bus offsets
// ****************************************
`define MMRB_OFF_CAUSE_CLR 12'h80a
`define MMRB_OFF_MEM_IDENT 12'h80b
`define MMRB_OFF_HB_CLEAR 12'h80c
`define MMRB_OFF_BOARD_CTL 12'h80d
`define MMRB_OFF_CAUSE_RD 12'h80e
`define MMRB_OFF_BCACHE 12'h80f
`define MMRB_OFF_CAUSE_SET 12'h82e

// ****************************************
// reset-cause fields
// ****************************************
`define MMRB_CAUSE_WDT 0
`define MMRB_CAUSE_PANEL 1
`define MMRB_CAUSE_VME 2
`define MMRB_CAUSE_PWRUP 3
`define MMRB_CAUSE_DIAG 4
`define MMRB_CAUSE_CLR_MASK 5'h0f
`define MMRB_CAUSE_SET_ALL 5'h1f
`define MMRB_CAUSE_PWRUP_VAL 5'h08

// ****************************************
// reset values
// ****************************************
`define MMRB_CTL_RESET 8'h00
`define MMRB_RDATA_UNMAPPED 8'h00

`endif

// ---- hdl/mmrb_pkg.sv ----
// types shared by the misc register bank
package mmrb_pkg;

  // one local bus request, sampled on mclk
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } mmrb_nb_req_t;

  // board control register layout
  typedef struct packed {
    logic tmr0_inv;
    logic rsv6;
    logic wdt_en;
    logic rsv4;
    logic flash_sw;
    logic flash_we;
    logic [1:0] flash_win;
  } mmrb_ctl_t;

  // pin inputs that pass the synchroniser
  typedef struct packed {
    logic [7:0] mem_id;
    logic [2:0] bcache;
    logic flash_sw;
    logic hb_clk;
    logic wdt_expire;
    logic panel_reset;
    logic vme_reset;
    logic tmr0_gate;
  } mmrb_pins_t;

endpackage : mmrb_pkg

// ---- tb/mmrb_bank_asserts.sv ----
// port-level checker for the misc register bank
`timescale 1ns/1ps
module mmrb_bank_asserts (
  input wire logic mclk,
  input wire logic resetn,
  input wire mmrb_pkg::mmrb_nb_req_t nb_req,
  input wire logic [7:0] nb_rdata,
  input wire logic nb_rvalid,
  input wire logic flash_sw_pin,
  input wire logic hb_clk_pin,
  input wire logic wdt_expire_pin,
  input wire logic panel_reset_pin,
  input wire logic vme_reset_pin,
  input wire logic [1:0] flash_win,
  input wire logic flash_we,
  input wire logic hb_irq,
  input wire logic board_reset_req
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [3:0] quiet_ff;
  wire ctl_wr = nb_req.wr && nb_req.addr == 12'h80d;
  wire hb_wr = nb_req.wr && nb_req.addr == 12'h80c;
  // ****************************************
  // cycles since any reset source was high
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!resetn || panel_reset_pin || vme_reset_pin || wdt_expire_pin) begin
      quiet_ff <= 4'h0;
    end else if (quiet_ff != 4'hf) begin
      quiet_ff <= quiet_ff + 4'h1;
    end
  end
  AST_RVALID: assert property (nb_req.rd ##1 !nb_req.rd |-> nb_rvalid ##1 !nb_rvalid)
    else $error("read valid is not a single pulse");
  AST_UNMAPPED: assert property (nb_req.rd && nb_req.addr[11:4] == 8'h81 |=> nb_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CTL_READBACK: assert property (ctl_wr ##1 !ctl_wr
    ##1 (nb_req.rd && nb_req.addr == 12'h80d)
    |=> (nb_rdata & 8'hf7) == ($past(nb_req.wdata, 3) & 8'ha7))
    else $error("control readback wrong");
  AST_CTL_WIN: assert property (ctl_wr ##1 !ctl_wr
    |=> {6'h00, flash_win} == ($past(nb_req.wdata, 2) & 8'h03))
    else $error("flash window not taken from control write");
  AST_FLASH_SW: assert property (!flash_sw_pin [*5] |-> !flash_we)
    else $error("flash write enabled with switch off");
  AST_HB_SET: assert property ($rose(hb_clk_pin) ##1 !hb_wr [*4] |-> hb_irq)
    else $error("heartbeat edge did not raise request");
  AST_HB_HOLD: assert property (hb_irq && !hb_wr |=> hb_irq)
    else $error("heartbeat request dropped without clear");
  AST_HB_CLEAR: assert property (!hb_clk_pin [*5] ##0 hb_wr |=> !hb_irq)
    else $error("heartbeat clear write ignored");
  AST_QUIET: assert property (quiet_ff > 4'h5 |-> !board_reset_req)
    else $error("board reset with no source");
  AST_RST_CLEAR: assert property (disable iff (1'b0) !resetn |=> flash_win == 2'h0 && !flash_we && !hb_irq)
    else $error("outputs not cleared by reset");
  cover property (hb_irq ##1 !hb_irq);
  cover property (board_reset_req);
  cover property (flash_we);
endmodule : mmrb_bank_asserts

bind mmrb_bank mmrb_bank_asserts mmrb_bank_asserts_i (.mclk, .resetn, .nb_req, .nb_rdata,
  .nb_rvalid, .flash_sw_pin, .hb_clk_pin, .wdt_expire_pin, .panel_reset_pin, .vme_reset_pin,
  .flash_win, .flash_we, .hb_irq, .board_reset_req);

// ---- tb/tb_mmrb_bank.sv ----
// self-checking bench of the misc register bank
`timescale 1ns/1ps
module tb_mmrb_bank;
  logic mclk = 0, resetn = 0, pwr_on_n = 0, sw = 0, hb = 0, wdt = 0, pnl = 0, vme = 0, gp = 0;
  logic [7:0] mid = 8'h00, rdata, d;
  logic [2:0] bc = 3'h0;
  logic [1:0] win;
  logic we, gate, irq, rst_req, rvalid;
  mmrb_pkg::mmrb_nb_req_t q = '0;
  int err_count = 0, n_compared = 0;
  always #10 mclk = ~mclk;
  mmrb_bank mmrb_bank_i (.mclk(mclk), .resetn(resetn), .pwr_on_n(pwr_on_n), .nb_req(q),
    .nb_rdata(rdata), .nb_rvalid(rvalid), .mem_id_pins(mid), .bcache_pins(bc),
    .flash_sw_pin(sw), .hb_clk_pin(hb), .wdt_expire_pin(wdt), .panel_reset_pin(pnl),
    .vme_reset_pin(vme), .counter_zero_gate_pin(gp), .flash_win(win), .flash_we(we),
    .counter_zero_gate(gate), .hb_irq(irq), .board_reset_req(rst_req));
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    q.addr = a;
    q.wdata = v;
    q.wr = 1'b1;
    tick(1);
    q.wr = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    q.addr = a;
    q.rd = 1'b1;
    tick(1);
    q.rd = 1'b0;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
    tick(1);
  endtask : rd
  // bounded look for a board reset request over eight cycles
  task automatic watch(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      tick(1);
      seen = seen | rst_req;
    end
    chk({7'h00, seen}, {7'h00, exp});
    if (exp && !seen) end_sim();
  endtask : watch
  function automatic logic [7:0] exp_ctl(input logic [7:0] v, input logic s);
    return (v & 8'ha7) | {4'h0, s, 3'h0};
  endfunction : exp_ctl
  initial begin
    #1000000;
    err_count++;
    end_sim();
  end
  initial begin
    d = 8'($urandom(94));
    tick(16);
    pwr_on_n = 1'b1;
    resetn = 1'b1;
    rd(12'h80a, 8'h08);
    rd(12'h80d, 8'h00);
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h04 : 8'($urandom);
      sw = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($urandom);
      gp = 1'($urandom);
      tick(3);
      wr(12'h80d, d);
      rd(12'h80d, exp_ctl(d, sw));
      chk({6'h00, win}, {6'h00, d[1:0]});
      chk({7'h00, we}, {7'h00, d[2] & sw});
      chk({7'h00, gate}, {7'h00, gp ^ d[7]});
    end
    $display("done: control register");
    for (int k = 0; k < 3; k++) begin
      mid = (k == 0) ? 8'haa : 8'($urandom);
      bc = (k == 0) ? 3'h2 : 3'($urandom);
      wr(12'h80b, 8'hff);
      wr(12'h80f, 8'hff);
      tick(3);
      rd(12'h80b, mid);
      rd(12'h80f, {5'h00, bc});
      rd(12'h810, 8'h00);
    end
    $display("done: read-only registers");
    hb = 1'b1;
    tick(2);
    hb = 1'b0;
    tick(8);
    chk({7'h00, irq}, 8'h01);
    wr(12'h80c, 8'($urandom));
    tick(1);
    chk({7'h00, irq}, 8'h00);
    rd(12'h80c, 8'h00);
    $display("done: heartbeat");
    wr(12'h80e, 8'h00);
    rd(12'h80e, 8'h08);
    wr(12'h82e, 8'h00);
    rd(12'h80e, 8'h1f);
    wr(12'h80a, 8'hff);
    rd(12'h82e, 8'h10);
    pnl = 1'b1;
    watch(1'b0);
    pnl = 1'b0;
    rd(12'h80a, 8'h12);
    wr(12'h80d, 8'h20);
    wdt = 1'b1;
    watch(1'b0);
    wdt = 1'b0;
    rd(12'h80a, 8'h13);
    $display("done: cause aliases");
    pwr_on_n = 1'b0;
    tick(4);
    pwr_on_n = 1'b1;
    tick(3);
    rd(12'h80a, 8'h08);
    wr(12'h80a, 8'h08);
    wr(12'h80d, 8'h20);
    wdt = 1'b1;
    watch(1'b1);
    wdt = 1'b0;
    rd(12'h80a, 8'h01);
    resetn = 1'b0;
    tick(4);
    resetn = 1'b1;
    tick(2);
    rd(12'h80d, exp_ctl(8'h00, sw));
    rd(12'h80a, 8'h01);
    wdt = 1'b1;
    watch(1'b0);
    wdt = 1'b0;
    vme = 1'b1;
    watch(1'b1);
    vme = 1'b0;
    rd(12'h80a, 8'h05);
    $display("done: reset causes");
    end_sim();
  end
endmodule : tb_mmrb_bank
